// [verilog/scsp_pkg.sv]
// Purpose: Constants and carrier types of the serial control and status port.
// Assumes: A 16-bit command word in, a 16-bit status word out, LSB first.
// Notes: All timing derives from the host shift clock and select sampled on mclk_i.
// What this block does
// - Capture input bit on shift clock fall
// - Apply command only when select rises
// - Output high impedance while select high
// - Enable output driver when select falls
// - Change output only on select fall or shift clock rise
// - Send status LSB first, bit0 prewarning
// - Status word is sixteen bits wide
package scsp_pkg;
  // ==========================================================================
  // Word layout
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int CLEAR_BIT = 0;
  localparam int PREWARN_BIT = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  // ==========================================================================
  // Pin carrier after synchronisation
  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic serial_in_pin;
  } link_pins_t;

  typedef struct packed {
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [15:0] command;
    logic [4:0] count;
    logic out_bit;
    logic out_en;
    logic cmd_strobe;
    link_pins_t prev;
  } port_state_t;
endpackage : scsp_pkg

// [verilog/scsp_sync.sv]
// Purpose: Two-stage synchroniser for the three host pins.
// Assumes: Pins are asynchronous to mclk_i.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/10ps
`default_nettype none
module scsp_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire scsp_pkg::link_pins_t pins_i,
  output scsp_pkg::link_pins_t pins_o
);
  typedef struct packed {
    scsp_pkg::link_pins_t meta;
    scsp_pkg::link_pins_t settled;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // ==========================================================================
  // Stages
  always_comb begin
    s_d.meta = pins_i;
    s_d.settled = s_q.meta;
  end

  // Select resets high so that no frame is seen during reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{meta: '{sel_n: 1'b1, sclk: 1'b0, serial_in_pin: 1'b0},
               settled: '{sel_n: 1'b1, sclk: 1'b0, serial_in_pin: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_o = s_q.settled;
endmodule // scsp_sync
`default_nettype wire

// [verilog/serial_control_status_port.sv]
// Purpose: Serial control and status port of a six-channel load driver.
// Assumes: Shift clock well below mclk_i/4; host idles the clock low.
// Notes: Edges are found on synchronised pins, so all actions lag by 3 cycles.
`timescale 1ns/10ps
`default_nettype none
module serial_control_status_port (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic serial_in_pin_i,
  input wire logic [15:0] status_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic [15:0] command_o,
  output logic command_strobe_o,
  output logic status_clear_request_o
);
  scsp_pkg::link_pins_t pins;
  scsp_pkg::port_state_t s_q;
  scsp_pkg::port_state_t s_d;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  logic sclk_rise;

  // ==========================================================================
  // Pin synchronisation
  scsp_sync u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pins_i('{sel_n: sel_n_i, sclk: sclk_i, serial_in_pin: serial_in_pin_i}),
    .pins_o(pins)
  );

  assign sel_fall = s_q.prev.sel_n && !pins.sel_n;
  assign sel_rise = !s_q.prev.sel_n && pins.sel_n;
  assign sclk_fall = s_q.prev.sclk && !pins.sclk && !pins.sel_n;
  assign sclk_rise = !s_q.prev.sclk && pins.sclk && !pins.sel_n;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.prev = pins;
    s_d.cmd_strobe = 1'b0;
    if (sel_fall) begin
      s_d.out_en = 1'b1;
      s_d.count = '0;
      // The snapshot keeps the word coherent while live status moves.
      s_d.shift_out = status_i;
      s_d.out_bit = status_i[scsp_pkg::PREWARN_BIT];
    end else if (sclk_rise && s_q.out_en) begin
      // First rise keeps bit 0; later rises advance one place.
      if (s_q.count != '0) begin
        s_d.shift_out = {1'b0, s_q.shift_out[15:1]};
        s_d.out_bit = s_q.shift_out[1];
      end
    end
    if (sclk_fall) begin
      // LSB arrives first, so bits enter at the top and move down.
      s_d.shift_in = {pins.serial_in_pin, s_q.shift_in[15:1]};
      if (s_q.count != 5'h1f) begin
        s_d.count = s_q.count + 5'h01;
      end
    end
    if (sel_rise) begin
      s_d.out_en = 1'b0;
      // A short or long frame would misalign the word, so it is dropped.
      if (s_q.count == 5'(scsp_pkg::WORD_W)) begin
        s_d.command = s_q.shift_in;
        s_d.cmd_strobe = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{shift_in: scsp_pkg::SHIFT_RESET,
               shift_out: scsp_pkg::SHIFT_RESET,
               command: scsp_pkg::CMD_RESET, count: 5'h00, out_bit: 1'b0,
               out_en: 1'b0, cmd_strobe: 1'b0,
               prev: '{sel_n: 1'b1, sclk: 1'b0, serial_in_pin: 1'b0}};
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_out_o = s_q.out_bit;
  assign serial_out_oe_o = s_q.out_en;
  assign command_o = s_q.command;
  assign command_strobe_o = s_q.cmd_strobe;
  assign status_clear_request_o =
    s_q.cmd_strobe && s_q.command[scsp_pkg::CLEAR_BIT];

  // ==========================================================================
  // Checks: output enable
  oe_off_high_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_rise |=> !serial_out_oe_o)
    else $error("output enabled after select rose");

  oe_on_fall_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_fall |=> serial_out_oe_o)
    else $error("output not enabled after select fell");

  oe_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (serial_out_oe_o && !sel_rise) |=> serial_out_oe_o)
    else $error("output enable dropped inside a frame");

  oe_idle_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!serial_out_oe_o && !sel_fall) |=> !serial_out_oe_o)
    else $error("output enabled outside a frame");

  // The raw pin is watched so that the synchroniser delay is bounded too.
  pin_fall_oe_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(sel_n_i) |-> ##[2:4] serial_out_oe_o)
    else $error("output enable late after select fell");

  pin_rise_oe_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(sel_n_i) |-> ##[2:4] !serial_out_oe_o)
    else $error("output enable still on after select rose");

  // ==========================================================================
  // Checks: serial output
  out_rise_only_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!sel_fall && !sclk_rise) |=> $stable(serial_out_o))
    else $error("serial output moved without a clock rise");

  out_idle_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!serial_out_oe_o && !sel_fall) |=> $stable(serial_out_o))
    else $error("serial output moved outside a frame");

  snap_load_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_fall |=> serial_out_o == $past(status_i[0]))
    else $error("status bit 0 not presented at frame start");

  snap_word_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_fall |=> s_q.shift_out == $past(status_i))
    else $error("status word not captured whole at frame start");

  snap_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (serial_out_oe_o && !sclk_rise && !sel_fall) |=> $stable(s_q.shift_out))
    else $error("status snapshot changed inside a frame");

  shift_lsb_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sclk_rise && s_q.out_en && s_q.count != 5'h00 && !sel_fall)
    |=> serial_out_o == $past(s_q.shift_out[1]))
    else $error("status not shifted LSB first");

  first_rise_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sclk_rise && s_q.out_en && s_q.count == 5'h00) |=> $stable(serial_out_o))
    else $error("status bit 0 lost at the first clock rise");

  // Bits past the sixteenth read as zero, never as stale status.
  zero_fill_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sclk_rise && s_q.out_en && s_q.count != 5'h00) |=> !s_q.shift_out[15])
    else $error("status shifter not filled with zero");

  // ==========================================================================
  // Checks: input and command
  cap_fall_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sclk_fall |=> s_q.shift_in[15] == $past(pins.serial_in_pin))
    else $error("input bit not captured on clock fall");

  count_step_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sclk_fall && s_q.count != 5'h1f) |=> s_q.count == $past(s_q.count) + 5'h01)
    else $error("bit count did not advance on clock fall");

  in_static_rise_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sclk_rise |=> $stable(s_q.shift_in))
    else $error("input shifted on a clock rise");

  idle_ignore_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (pins.sel_n && s_q.prev.sel_n) |=> $stable(s_q.shift_in) &&
    $stable(s_q.count))
    else $error("input shifted while select was high");

  cmd_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !sel_rise |=> $stable(command_o))
    else $error("command changed outside select rise");

  cmd_apply_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sel_rise && s_q.count == 5'h10) |=> command_strobe_o &&
    command_o == $past(s_q.shift_in))
    else $error("command not applied at select rise");

  width_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sel_rise && s_q.count != 5'h10) |=> !command_strobe_o)
    else $error("command taken from a frame of wrong length");

  strobe_pulse_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    command_strobe_o |=> !command_strobe_o)
    else $error("command strobe longer than one cycle");

  strobe_cause_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    command_strobe_o |-> $past(sel_rise))
    else $error("command strobe without a select rise");

  cmd_quiet_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !pins.sel_n |=> !command_strobe_o)
    else $error("command applied while bits were shifting");

  // ==========================================================================
  // Coverage
  frame_c: cover property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    command_strobe_o);

  clear_c: cover property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    status_clear_request_o);

  short_c: cover property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_rise && s_q.count != 5'h10);

  snap_c: cover property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sel_fall);

  shift_c: cover property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    sclk_rise && s_q.out_en && s_q.count != 5'h00);
endmodule // serial_control_status_port
`default_nettype wire

// [testbench/scsp_host.sv]
// Purpose: Host model that runs frames on the serial port.
// Assumes: Shift clock of 80 ns, idle low outside frames.
// Notes: Each output bit is read twice while the clock is high.
`timescale 1ns/10ps
`default_nettype none
module scsp_host (
  input wire logic mclk_i,
  input wire logic serial_line_i,
  output logic sel_n_o = 1'b1,
  output logic sclk_o = 1'b0,
  output logic serial_in_pin_o = 1'b0
);
  // ==========================================================================
  // Frame
  task automatic frame(input logic [15:0] cmd, input int nbits,
                       output logic [15:0] stat, output logic steady);
    logic early;
    stat = 16'h0000;
    steady = 1'b1;
    @(posedge mclk_i) sel_n_o <= 1'b0;
    for (int k = 0; k < nbits; k++) begin
      repeat (4) @(posedge mclk_i);
      serial_in_pin_o <= cmd[k];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (5) @(posedge mclk_i);
      early = serial_line_i;
      repeat (3) @(posedge mclk_i);
      steady &= (serial_line_i === early);
      stat[k] = serial_line_i;
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge mclk_i);
    sel_n_o <= 1'b1;
    // The data line is left at the inverse so stale bits cannot match.
    serial_in_pin_o <= ~cmd[nbits-1];
    repeat (8) @(posedge mclk_i);
  endtask
endmodule // scsp_host
`default_nettype wire

// [testbench/serial_control_status_port_tb_top.sv]
// Purpose: Self-checking bench of the serial control and status port.
// Assumes: Host model drives all pins; status_i is set by the bench.
// Notes: A released output line reads as the inverse of its last bit.
`timescale 1ns/10ps
`default_nettype none
module serial_control_status_port_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] status = 16'h0000;
  logic sel_n, sclk, din, sout, oe, strobe, clear, last_q = 1'b0, line;
  logic [15:0] command;
  int n_mismatch = 0, checks = 0, n_strobe = 0, n_clear = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (oe === 1'b1) last_q <= sout;
    if (strobe === 1'b1) n_strobe++;
    if (clear === 1'b1) n_clear++;
  end
  assign line = (oe === 1'b1) ? sout : ~last_q;
  scsp_host host (.mclk_i(mclk), .serial_line_i(line), .sel_n_o(sel_n),
    .sclk_o(sclk), .serial_in_pin_o(din));
  serial_control_status_port dut (.mclk_i(mclk), .rst_n_i(rst_n),
    .sel_n_i(sel_n), .sclk_i(sclk), .serial_in_pin_i(din),
    .status_i(status), .serial_out_o(sout), .serial_out_oe_o(oe),
    .command_o(command), .command_strobe_o(strobe),
    .status_clear_request_o(clear));
  // ==========================================================================
  // Checking and closing
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic run_frame(input logic [15:0] cmd, input int nbits,
                           input logic [15:0] st);
    logic [15:0] stat, old;
    logic steady, ok;
    int s0, c0;
    old = command;
    s0 = n_strobe;
    c0 = n_clear;
    ok = (nbits == 16);
    status <= st;
    @(posedge mclk);
    fork
      host.frame(cmd, nbits, stat, steady);
      begin
        repeat (30) @(posedge mclk);
        status <= ~st;
        check("oe in frame", {15'h0000, oe}, 16'h0001);
        check("command in frame", command, old);
      end
    join
    check("status", stat, st);
    check("steady", {15'h0000, steady}, 16'h0001);
    check("oe idle", {15'h0000, oe}, 16'h0000);
    check("command", command, ok ? cmd : old);
    check("strobes", 16'(n_strobe - s0), {15'h0000, ok});
    check("clears", 16'(n_clear - c0), {15'h0000, ok & cmd[0]});
  endtask
  initial begin
    #20000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check("oe reset", {15'h0000, oe}, 16'h0000);
    run_frame(16'h8001, 16, 16'ha5c3);
    run_frame(16'h7ffe, 16, 16'h5a3c);
    run_frame(16'h1235, 15, 16'h0f0f);
    stop_test();
  end
endmodule // serial_control_status_port_tb_top
`default_nettype wire
